// ===== tb_watchdog_reset_timer.sv
// Testbench of the watchdog reset timer: register tasks, random reloads, corner cases.
// Assumes the offsets of wrt_pkg and a machine cycle of twelve clocks.
`default_nettype none

module tb_watchdog_reset_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import wrt_pkg::*;

  localparam logic [15:0] OVF = 16'h0020;  // Short fire count keeps the run brief.
  localparam logic [7:0] OFS_TAB [9] = '{OFS_IEN_FIRST, OFS_IEN_SECOND, OFS_IPRIO_FIRST,
    OFS_RELOAD, OFS_CNT_LO, OFS_CNT_HI, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h10};

  logic         i_clk      = 1'b0;          // Oscillator clock.
  logic         i_rst      = 1'b1;          // External reset, held at start.
  logic         i_idle     = 1'b0;          // Idle request.
  wrt_bus_req_t bus        = '0;            // Register port request.
  logic [7:0]   rdata;                      // Read data.
  logic         wd_reset;                   // Internal watchdog reset.
  logic         running;                    // Watchdog enabled.
  logic         irq;                        // Interrupt level.
  int           mismatches = 0;             // Failed comparisons.
  int           num_checks = 0;             // All comparisons.
  int           seed       = 32'h66f893d7;  // Fixed seed keeps runs repeatable.
  logic [7:0]   rv, wv, rel;                // Read, written and reload values.
  int           n;                          // Cycle count of bounded waits.
  time          t0;                         // Moment of the last refresh.

  wrt_watchdog_reset_timer #(.OVF_COUNT(OVF)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata), .i_idle(i_idle),
    .o_wd_reset(wd_reset), .o_running(running), .o_irq(irq));

  // Free-running 50 MHz clock.
  always #10 i_clk = ~i_clk;

  // Compares a seen value against the expected one.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Counter steps expected over a span of clocks: one per twelve-clock machine cycle.
  function automatic logic [7:0] exp_ticks(input int clocks);
    exp_ticks = 8'(clocks / 12);
  endfunction

  // One-cycle write; returns just after the accepting edge has landed.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  // One-cycle read; data stand only in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Two low-byte reads exactly gap clocks apart, optionally with a plain start between.
  task automatic lo_gap(input int gap, input logic poke, output logic [7:0] diff);
    logic [7:0] a, b;
    rd(OFS_CNT_LO, a);
    if (poke)
    begin
      wr(OFS_IEN_SECOND, 8'h40);
      repeat (gap - 4) @(posedge i_clk);
    end
    else
      repeat (gap - 2) @(posedge i_clk);
    rd(OFS_CNT_LO, b);
    diff = b - a;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog on the bench itself: the tests need under 1000 clocks.
  initial
  begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    print_verdict();
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      rd(OFS_TAB[i], rv);
      chk(rv, 8'h00);
    end
    chk({6'h00, running, irq}, 8'h00);
    $display("test reset values done");
    // Other enable bits are only stored; a plain start never loads the reload value.
    rel = 8'($random(seed)) | 8'h01;
    wr(OFS_RELOAD, rel);
    wv = 8'($random(seed)) & 8'hbf;
    wr(OFS_IEN_FIRST, wv);
    rd(OFS_IEN_FIRST, rv);
    chk(rv, wv);
    chk({7'h00, running}, 8'h00);
    wr(OFS_IEN_SECOND, 8'h40);
    chk({7'h00, running}, 8'h01);
    rd(OFS_CNT_HI, rv);
    chk(rv, 8'h00);
    rd(OFS_IPRIO_FIRST, rv);
    chk(rv, 8'h40);
    rd(OFS_IRQ_STAT, rv);
    chk(rv, 8'h01);
    $display("test plain start done");
    // Eight machine cycles add eight, also across a second plain start; idle adds nothing.
    lo_gap(96, 1'b0, rv);
    chk(rv, exp_ticks(96));
    lo_gap(96, 1'b1, rv);
    chk(rv, exp_ticks(96));
    @(posedge i_clk) i_idle <= 1'b1;
    lo_gap(96, 1'b0, rv);
    chk(rv, 8'h00);
    @(posedge i_clk) i_idle <= 1'b0;
    $display("test counting done");
    // Arm then start loads the reload value; the last pass clears the count.
    for (int i = 0; i < 3; i++)
    begin
      rel = (i == 2) ? 8'h00 : 8'($random(seed));
      wr(OFS_RELOAD, rel);
      wr(OFS_IEN_FIRST, 8'h40);
      wr(OFS_IEN_SECOND, 8'h40);
      t0 = $time;
      rd(OFS_CNT_HI, rv);
      chk(rv, rel);
    end
    rd(OFS_IEN_FIRST, rv);
    chk(rv, 8'h40);
    rd(OFS_IEN_SECOND, rv);
    chk(rv, 8'h40);
    repeat (30) @(posedge i_clk);
    rd(OFS_IEN_FIRST, rv);
    chk(rv, 8'h00);
    rd(OFS_IEN_SECOND, rv);
    chk(rv, 8'h00);
    rd(OFS_CNT_LO, rv);
    chk(8'(rv <= 8'h04), 8'h01);
    $display("test refresh done");
    // Left alone, the count runs out and a four-cycle reset follows.
    wr(OFS_RELOAD, 8'h33);
    wr(OFS_IEN_FIRST, 8'h05);
    n = 0;
    while (wd_reset !== 1'b1 && n < 1000)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    n = int'(($time - t0) / 20);
    chk(8'(n >= 384 && n <= 400), 8'h01);
    n = 0;
    while (wd_reset === 1'b1 && n < 100)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(8'(n), 8'h30);
    chk({7'h00, running}, 8'h01);
    rd(OFS_RELOAD, rv);
    chk(rv, 8'h00);
    rd(OFS_IEN_FIRST, rv);
    chk(rv, 8'h00);
    rd(OFS_IPRIO_FIRST, rv);
    chk(rv, 8'h40);
    // Software cannot clear the status bit; the other priority bits are stored.
    wr(OFS_IPRIO_FIRST, 8'h81);
    rd(OFS_IPRIO_FIRST, rv);
    chk(rv, 8'hc1);
    rd(OFS_IRQ_STAT, rv);
    chk(rv, 8'h07);
    $display("test overflow done");
    // Interrupt level follows status and mask; a written one clears status.
    chk({7'h00, irq}, 8'h00);
    wr(OFS_IRQ_MASK, 8'h04);
    chk({7'h00, irq}, 8'h01);
    wr(OFS_IRQ_STAT, 8'h04);
    chk({7'h00, irq}, 8'h00);
    rd(OFS_IRQ_STAT, rv);
    chk(rv, 8'h03);
    $display("test interrupt done");
    // External reset disables and clears everything.
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk({6'h00, running, wd_reset}, 8'h00);
    rd(OFS_IPRIO_FIRST, rv);
    chk(rv, 8'h00);
    rd(OFS_CNT_LO, rv);
    chk(rv, 8'h00);
    // A refresh from the stopped state both starts the counter and loads it.
    wr(OFS_RELOAD, 8'h5a);
    wr(OFS_IEN_FIRST, 8'h40);
    wr(OFS_IEN_SECOND, 8'h40);
    rd(OFS_CNT_HI, rv);
    chk(rv, 8'h5a);
    chk({7'h00, running}, 8'h01);
    $display("test external reset done");
    print_verdict();
  end

endmodule // tb_watchdog_reset_timer

`default_nettype wire

// ===== wrt_clk_gen.sv
// Internal clock generator of the watchdog reset timer.
// Assumes i_clk is the oscillator; emits one-cycle enables, never new clocks.
`default_nettype none

module wrt_clk_gen (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Enables.
  output logic      o_state_en,
  output logic      o_mc_en
);
  import wrt_pkg::*;

  logic       half_ff;   // Divide-by-two phase of the oscillator.
  logic [2:0] state_ff;  // State counter within one machine cycle.
  logic       nxt_half;  // Next divide phase.
  logic [2:0] nxt_state; // Next state count.
  logic       last_st;   // Final state of a machine cycle.

  // The internal timing runs at half the oscillator rate.
  assign nxt_half  = (half_ff == OSC_PER_STATE_M1) ? 1'b0 : 1'b1;
  assign last_st   = (state_ff == STATES_PER_MC_M1);
  assign nxt_state = last_st ? 3'h0 : state_ff + 3'h1;

  // Enables are pure decodes of the counters, so both are single-cycle pulses.
  assign o_state_en = (half_ff == OSC_PER_STATE_M1);
  assign o_mc_en    = o_state_en && last_st;

  // Divider registers; one machine cycle spans twelve oscillator periods.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      half_ff  <= 1'b0;
      state_ff <= 3'h0;
    end
    else
    begin
      half_ff <= nxt_half;
      if (o_state_en)
      begin
        state_ff <= nxt_state;
      end
    end
  end

endmodule // wrt_clk_gen

`default_nettype wire

// ===== wrt_pkg.sv
// Package of the watchdog reset timer: register offsets, bit positions,
// reset values, cycle counts, the bus request carrier and the state type.
// Assumes an 8-bit special function register space reached over a plain port.
`default_nettype none

package wrt_pkg;

  // Bus request as it travels from the register port into the block.
  typedef struct packed {
    logic [7:0] addr;   // Register offset.
    logic [7:0] wdata;  // Write data.
    logic       wr;     // One-cycle write strobe.
    logic       rd;     // One-cycle read strobe.
  } wrt_bus_req_t;

  // Register offsets in the special function register space.
  localparam logic [7:0] OFS_IEN_FIRST   = 8'ha8;
  localparam logic [7:0] OFS_IEN_SECOND  = 8'hb8;
  localparam logic [7:0] OFS_IPRIO_FIRST = 8'ha9;
  localparam logic [7:0] OFS_RELOAD      = 8'hc1;
  localparam logic [7:0] OFS_CNT_LO      = 8'hc2;
  localparam logic [7:0] OFS_CNT_HI      = 8'hc3;
  localparam logic [7:0] OFS_IRQ_STAT    = 8'hc4;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'hc5;

  // Bit positions of the watchdog flags inside their registers.
  localparam int unsigned BIT_ARM    = 6;
  localparam int unsigned BIT_START  = 6;
  localparam int unsigned BIT_STATUS = 6;

  // Interrupt status bit positions and width.
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned IRQ_START   = 0;
  localparam int unsigned IRQ_REFRESH = 1;
  localparam int unsigned IRQ_WDRST   = 2;

  // Values after reset.
  localparam logic [7:0]       REG_RST  = 8'h00;
  localparam logic [15:0]      CNT_ZERO = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;

  // Counts, all in machine cycles unless said otherwise.
  localparam logic [1:0]  FLAG_LIFE_MC  = 2'h2;    // Self-clear of arm and start flags.
  localparam logic [2:0]  RST_LEN_MC    = 3'h4;    // Length of the watchdog reset.
  localparam logic [15:0] OVF_COUNT_DEF = 16'hfffc; // Counter state that fires the reset.
  localparam int unsigned TIMEOUT_US    = 65532;   // Timeout at a 12 MHz oscillator.

  // Clock generator: oscillator periods per state and states per machine cycle.
  localparam logic       OSC_PER_STATE_M1 = 1'h1;
  localparam logic [2:0] STATES_PER_MC_M1 = 3'h5;

  // Watchdog operating states.
  typedef enum logic [1:0] {
    WRT_OFF,
    WRT_RUN,
    WRT_RESET
  } wrt_state_t;

endpackage

`default_nettype wire

// ===== wrt_properties.sv
// Checker of the watchdog reset timer: assertions on the top module ports.
// Assumes the offsets of wrt_pkg and a machine cycle of twelve clocks.
`default_nettype none

module wrt_properties #(
  parameter logic [15:0] OVF_COUNT = 16'hfffc  // Fire count, handed on by the bind.
) (
  // Clock and reset.
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  // Register port.
  input wire wrt_pkg::wrt_bus_req_t i_bus,
  input wire logic [7:0]            o_rdata,
  // Power control and status.
  input wire logic                  i_idle,
  input wire logic                  o_wd_reset,
  input wire logic                  o_running,
  input wire logic                  o_irq
);
  import wrt_pkg::*;

  // Accepted flag writes; the design drops them while its own reset stands.
  wire logic  arm_wr   = i_bus.wr && i_bus.addr == OFS_IEN_FIRST && i_bus.wdata[BIT_ARM]
                         && !o_wd_reset;
  wire logic  start_wr = i_bus.wr && i_bus.addr == OFS_IEN_SECOND && i_bus.wdata[BIT_START]
                         && !o_wd_reset;
  logic [5:0] arm_age_ff;    // Clocks since the arm flag was set, saturating.
  logic [5:0] start_age_ff;  // Clocks since the start flag was set, saturating.
  logic [6:0] rst_len_ff;    // Clocks the watchdog reset has stood so far.

  // Flag ages saturate, so a long-quiet flag is still known to be clear.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || o_wd_reset)
    begin
      arm_age_ff   <= 6'h3f;
      start_age_ff <= 6'h3f;
    end
    else
    begin
      arm_age_ff   <= arm_wr ? 6'h00 : arm_age_ff + {5'h00, arm_age_ff != 6'h3f};
      start_age_ff <= start_wr ? 6'h00 : start_age_ff + {5'h00, start_age_ff != 6'h3f};
    end
  end

  // Length of the current watchdog reset; too long for a repetition operator.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !o_wd_reset)
      rst_len_ff <= 7'h00;
    else
      rst_len_ff <= rst_len_ff + 7'h01;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // A read strobe at one offset.
  sequence s_read(logic [7:0] ofs);
    i_bus.rd && i_bus.addr == ofs;
  endsequence

  a_ext_reset_quiet: assert property (disable iff (1'b0)
    i_rst |=> !o_running && !o_wd_reset && !o_irq && o_rdata == 8'h00)
    else $error("outputs not quiet after external reset");
  a_never_stops: assert property (o_running |=> o_running)
    else $error("watchdog stopped without external reset");
  a_wdrst_enabled: assert property (o_wd_reset |-> o_running)
    else $error("watchdog reset while disabled");
  a_wdrst_bound: assert property (o_wd_reset |-> rst_len_ff < 7'h30)
    else $error("watchdog reset longer than four machine cycles");
  a_wdrst_length: assert property ($fell(o_wd_reset) |-> rst_len_ff == 7'h30)
    else $error("watchdog reset shorter than four machine cycles");
  a_status_reads: assert property (s_read(OFS_IPRIO_FIRST)
    |=> o_rdata[BIT_STATUS] == $past(o_running))
    else $error("started status differs from enable");
  a_arm_held: assert property (s_read(OFS_IEN_FIRST) ##0 arm_age_ff <= 6'h09
    |=> o_rdata[BIT_ARM])
    else $error("arm flag cleared too early");
  a_arm_cleared: assert property (s_read(OFS_IEN_FIRST) ##0 arm_age_ff >= 6'h1b
    |=> !o_rdata[BIT_ARM])
    else $error("arm flag not cleared in time");
  a_start_held: assert property (s_read(OFS_IEN_SECOND) ##0 start_age_ff <= 6'h09
    |=> o_rdata[BIT_START])
    else $error("start flag cleared too early");
  a_start_cleared: assert property (s_read(OFS_IEN_SECOND) ##0 start_age_ff >= 6'h1b
    |=> !o_rdata[BIT_START])
    else $error("start flag not cleared in time");

endmodule // wrt_properties

bind wrt_watchdog_reset_timer wrt_properties #(.OVF_COUNT(OVF_COUNT)) u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata), .i_idle(i_idle),
  .o_wd_reset(o_wd_reset), .o_running(o_running), .o_irq(o_irq));

`default_nettype wire

// ===== wrt_watchdog_reset_timer.sv
// Watchdog reset timer: sixteen-bit counter, refresh sequence, internal reset.
// Assumes a plain register port with read data one cycle after the strobe,
// and an idle indication from the power control logic.
//
// Summary of operation
// - Missed clear within timeout starts internal reset.
// - Sixteen-bit counter, plus one per machine cycle.
// - External reset disables and zeroes the counter.
// - Writing start flag one starts the counter.
// - Start sets a readable started status flag.
// - Software writes can never stop the counter.
// - Clear only by arm then start sequence.
// - Arm flag self-clears in second machine cycle.
// - Start flag self-clears two cycles after set.
// - Plain start never copies the reload value.
// - Reaching the fire count gives four-cycle reset.
// - Watchdog reset acts like external, stays enabled.
// - Started status flag survives the watchdog reset.
// - Only arm bit of first enable register matters.
// - Machine cycles come at one twelfth oscillator rate.
// - Idle mode freezes the counter value.
`default_nettype none

module wrt_watchdog_reset_timer #(
  // Counter state that fires the reset; lower it only to shorten simulation.
  parameter logic [15:0] OVF_COUNT = wrt_pkg::OVF_COUNT_DEF
) (
  // Clock and reset.
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Register port.
  input  wire wrt_pkg::wrt_bus_req_t i_bus,
  output logic [7:0]                o_rdata,
  // Power control.
  input  wire logic                 i_idle,
  // Status and reset outputs.
  output logic                      o_wd_reset,
  output logic                      o_running,
  output logic                      o_irq
);
  import wrt_pkg::*;

  // Decode of an offset against the incoming address.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Ageing of a self-clearing flag: returns {flag, age} after one cycle.
  function automatic logic [2:0] flag_age(input logic set, input logic flag,
                                          input logic [1:0] age, input logic tick);
    logic [2:0] res;
    res = {flag, age};
    if (set)
    begin
      res = {1'b1, 2'h0};
    end
    else if (flag && tick)
    begin
      if (age == FLAG_LIFE_MC - 2'h1)
      begin
        res = {1'b0, 2'h0};
      end
      else
      begin
        res = {1'b1, age + 2'h1};
      end
    end
    flag_age = res;
  endfunction

  // Machine-cycle timing.
  logic                 mc_en;          // One pulse per machine cycle.

  // Watchdog state.
  wrt_state_t           state_ff;       // Off, running or holding reset.
  wrt_state_t           nxt_state;      // Next watchdog state.
  logic [15:0]          count_ff;       // The counter, high and low bytes.
  logic [15:0]          nxt_count;      // Next counter value.
  logic [2:0]           rst_len_ff;     // Machine cycles spent in reset.
  logic [2:0]           nxt_rst_len;    // Next reset length count.

  // Special function register storage.
  logic [7:0]           interrupt_enable_first_ff;   // Non-watchdog bits kept.
  logic [7:0]           interrupt_enable_second_ff;  // Non-watchdog bits kept.
  logic [7:0]           interrupt_priority_first_ff; // Non-watchdog bits kept.
  logic [7:0]           reload_value_reg_ff;         // Refresh load for high byte.
  logic                 refresh_arm_flag_ff;         // Arm flag.
  logic [1:0]           arm_age_ff;                  // Machine cycles since arm.
  logic                 start_refresh_flag_ff;       // Start/refresh flag.
  logic [1:0]           start_age_ff;                // Machine cycles since start.
  logic                 started_status_flag_ff;      // Set once started.
  logic [IRQ_W-1:0]     irq_stat_ff;                 // Sticky event bits.
  logic [IRQ_W-1:0]     irq_mask_ff;                 // Interrupt enables.
  logic [7:0]           rdata_ff;                    // Registered read data.

  // Decoded writes and events.
  logic                 wr_interrupt_enable_second;        // Write to first enable register.
  logic                 wr_ien2;        // Write to second enable register.
  logic                 wr_ip1;         // Write to first priority register.
  logic                 wr_rel;         // Write to reload register.
  logic                 wr_stat;        // Write to interrupt status.
  logic                 wr_mask;        // Write to interrupt mask.
  logic                 arm_set;        // Software sets the arm flag.
  logic                 start_set;      // Software sets the start flag.
  logic                 refresh;        // Valid two-step refresh.
  logic                 start_ev;       // First start from the off state.
  logic                 fire;           // Counter reached the fire count.
  logic                 ticking;        // Counter advances this cycle.
  logic                 in_reset;       // Internal reset is in progress.
  logic                 sfr_rst;        // Reset for ordinary register bits.
  logic [2:0]           nxt_arm;        // Next arm flag and age.
  logic [2:0]           nxt_start;      // Next start flag and age.
  logic [IRQ_W-1:0]     irq_set;        // Events raising status bits.
  logic [IRQ_W-1:0]     nxt_irq_stat;   // Next status bits.
  logic [7:0]           rd_mux;         // Read selection.
  logic [7:0]           interrupt_enable_second_view;      // Read view of first enable register.
  logic [7:0]           ien2_view;      // Read view of second enable register.
  logic [7:0]           ip1_view;       // Read view of first priority register.

  // The machine-cycle enable comes from the internal clock generator.
  wrt_clk_gen u_clk_gen (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .o_state_en (),
    .o_mc_en    (mc_en)
  );

  // Address decode of writes.
  assign wr_interrupt_enable_second = i_bus.wr && addr_hit(i_bus.addr, OFS_IEN_FIRST);
  assign wr_ien2 = i_bus.wr && addr_hit(i_bus.addr, OFS_IEN_SECOND);
  assign wr_ip1  = i_bus.wr && addr_hit(i_bus.addr, OFS_IPRIO_FIRST);
  assign wr_rel  = i_bus.wr && addr_hit(i_bus.addr, OFS_RELOAD);
  assign wr_stat = i_bus.wr && addr_hit(i_bus.addr, OFS_IRQ_STAT);
  assign wr_mask = i_bus.wr && addr_hit(i_bus.addr, OFS_IRQ_MASK);

  // Only the arm bit of the first enable register reaches the watchdog.
  assign arm_set   = wr_interrupt_enable_second && i_bus.wdata[BIT_ARM];
  assign start_set = wr_ien2 && i_bus.wdata[BIT_START];

  // While in reset the processor is held; only its interrupt status and mask writes are honoured.
  assign in_reset = (state_ff == WRT_RESET);

  // A refresh needs the start write while the arm flag is still alive; the
  // short arm life is what forces the start to come as the next instruction.
  assign refresh  = start_set && refresh_arm_flag_ff && !in_reset;
  assign start_ev = start_set && (state_ff == WRT_OFF);

  // The counter is frozen in idle mode.
  assign ticking = mc_en && !i_idle && (state_ff == WRT_RUN);
  assign fire    = ticking && (count_ff == OVF_COUNT) && !refresh;

  // The watchdog reset clears ordinary register bits like an external reset.
  assign sfr_rst = i_rst || in_reset;

  // Self-clearing of the arm and start flags on machine-cycle ticks.
  assign nxt_arm   = flag_age(arm_set && !in_reset, refresh_arm_flag_ff,
                              arm_age_ff, mc_en);
  assign nxt_start = flag_age(start_set && !in_reset, start_refresh_flag_ff,
                              start_age_ff, mc_en);

  // Next state of the watchdog; no write path leads back to off.
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_count   = count_ff;
    nxt_rst_len = rst_len_ff;
    case (state_ff)
      WRT_OFF:
      begin
        // Starting alone leaves the counter at zero; only a refresh loads it.
        if (refresh)
        begin
          nxt_count = {reload_value_reg_ff, 8'h00};
        end
        if (start_ev)
        begin
          nxt_state = WRT_RUN;
        end
      end
      WRT_RUN:
      begin
        if (refresh)
        begin
          nxt_count = {reload_value_reg_ff, 8'h00};
        end
        else if (fire)
        begin
          // Timeout: hold the chip in reset for four machine cycles.
          nxt_state   = WRT_RESET;
          nxt_count   = CNT_ZERO;
          nxt_rst_len = 3'h0;
        end
        else if (ticking)
        begin
          nxt_count = count_ff + 16'h0001;
        end
        // A start without a pending arm changes nothing here.
      end
      WRT_RESET:
      begin
        // The counter stays enabled and resumes from zero afterwards.
        if (mc_en)
        begin
          if (rst_len_ff == RST_LEN_MC - 3'h1)
          begin
            nxt_state = WRT_RUN;
          end
          else
          begin
            nxt_rst_len = rst_len_ff + 3'h1;
          end
        end
      end
      default:
      begin
        nxt_state = WRT_OFF;
        nxt_count = CNT_ZERO;
      end
    endcase
  end

  // Watchdog state registers; only external reset disables them.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_ff   <= WRT_OFF;
      count_ff   <= CNT_ZERO;
      rst_len_ff <= 3'h0;
    end
    else
    begin
      state_ff   <= nxt_state;
      count_ff   <= nxt_count;
      rst_len_ff <= nxt_rst_len;
    end
  end

  // The started status flag survives the watchdog reset, so software can
  // tell an overflow reset from a power-on one.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      started_status_flag_ff <= 1'b0;
    end
    else if (start_ev)
    begin
      started_status_flag_ff <= 1'b1;
    end
  end

  // Self-clearing flags, reset by either reset source.
  always_ff @(posedge i_clk)
  begin
    if (sfr_rst)
    begin
      refresh_arm_flag_ff   <= 1'b0;
      arm_age_ff            <= 2'h0;
      start_refresh_flag_ff <= 1'b0;
      start_age_ff          <= 2'h0;
    end
    else
    begin
      {refresh_arm_flag_ff, arm_age_ff}     <= nxt_arm;
      {start_refresh_flag_ff, start_age_ff} <= nxt_start;
    end
  end

  // Ordinary register storage; the watchdog reset clears it too.
  always_ff @(posedge i_clk)
  begin
    if (sfr_rst)
    begin
      interrupt_enable_first_ff   <= REG_RST;
      interrupt_enable_second_ff  <= REG_RST;
      interrupt_priority_first_ff <= REG_RST;
      reload_value_reg_ff         <= REG_RST;
    end
    else
    begin
      if (wr_interrupt_enable_second)
      begin
        interrupt_enable_first_ff <= i_bus.wdata;
      end
      if (wr_ien2)
      begin
        interrupt_enable_second_ff <= i_bus.wdata;
      end
      if (wr_ip1)
      begin
        interrupt_priority_first_ff <= i_bus.wdata;
      end
      if (wr_rel)
      begin
        reload_value_reg_ff <= i_bus.wdata;
      end
    end
  end

  // Interrupt events: start, refresh and the beginning of a watchdog reset.
  assign irq_set = {fire, refresh, start_ev};

  // Write-one-to-clear; an event in the clearing cycle wins over the clear.
  assign nxt_irq_stat = (irq_stat_ff & ~(wr_stat ? i_bus.wdata[IRQ_W-1:0] : IRQ_RST))
                        | irq_set;

  // Interrupt registers live outside the processor's reset domain, so the
  // watchdog reset event is still visible after the reset ends.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_stat_ff <= IRQ_RST;
      irq_mask_ff <= IRQ_RST;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_mask)
      begin
        irq_mask_ff <= i_bus.wdata[IRQ_W-1:0];
      end
    end
  end

  // Read views: the watchdog bits replace bit six of the stored bytes.
  assign interrupt_enable_second_view = {interrupt_enable_first_ff[7], refresh_arm_flag_ff,
                      interrupt_enable_first_ff[5:0]};
  assign ien2_view = {interrupt_enable_second_ff[7], start_refresh_flag_ff,
                      interrupt_enable_second_ff[5:0]};
  assign ip1_view  = {interrupt_priority_first_ff[7], started_status_flag_ff,
                      interrupt_priority_first_ff[5:0]};

  // Read selection; unmapped offsets read as zero.
  assign rd_mux =
      ({8{addr_hit(i_bus.addr, OFS_IEN_FIRST)}}   & interrupt_enable_second_view)
    | ({8{addr_hit(i_bus.addr, OFS_IEN_SECOND)}}  & ien2_view)
    | ({8{addr_hit(i_bus.addr, OFS_IPRIO_FIRST)}} & ip1_view)
    | ({8{addr_hit(i_bus.addr, OFS_RELOAD)}}      & reload_value_reg_ff)
    | ({8{addr_hit(i_bus.addr, OFS_CNT_LO)}}      & count_ff[7:0])
    | ({8{addr_hit(i_bus.addr, OFS_CNT_HI)}}      & count_ff[15:8])
    | ({8{addr_hit(i_bus.addr, OFS_IRQ_STAT)}}    & {5'h00, irq_stat_ff})
    | ({8{addr_hit(i_bus.addr, OFS_IRQ_MASK)}}    & {5'h00, irq_mask_ff});

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rdata_ff <= REG_RST;
    end
    else
    begin
      rdata_ff <= i_bus.rd ? rd_mux : REG_RST;
    end
  end

  // Outputs.
  assign o_rdata    = rdata_ff;
  assign o_wd_reset = in_reset;
  assign o_running  = (state_ff != WRT_OFF);
  assign o_irq      = |(irq_stat_ff & irq_mask_ff);

endmodule // wrt_watchdog_reset_timer

`default_nettype wire
